//--- ram_block_regs.svh
`ifndef RAM_BLOCK_REGS_SVH
`define RAM_BLOCK_REGS_SVH

// block size selector codes
`define SIZE_SMALL 2'h0
`define SIZE_MEDIUM 2'h1
`define SIZE_LARGE 2'h2

// default geometry of the medium block in its widest shape
`define DEF_WORDS 128
`define DEF_WIDTH 36
`define BYTE_WITH_PARITY 9

// widest shape of each block size: words by bits, parity included
`define SMALL_WORDS 32
`define SMALL_WIDTH 18
`define MEDIUM_WORDS 128
`define MEDIUM_WIDTH 36
`define LARGE_WORDS 4096
`define LARGE_WIDTH 144

// cleared value of every register under clear
`define CLEAR_VALUE 1'h0

`endif

//--- ram_block_pkg.sv
package ram_block_pkg;

  // port usage modes
  typedef enum logic [2:0] {
    mode_single = 3'b001,
    mode_simple_dual = 3'b010,
    mode_true_dual = 3'b100
  } ram_mode_t;

  // read-during-write choice for mixed-port collisions
  typedef enum logic [1:0] {
    rdw_old_data = 2'b01,
    rdw_dont_care = 2'b10
  } rdw_t;

  // static configuration bundle
  typedef struct packed {
    ram_mode_t mode;
    rdw_t rdw;
    logic out_reg_a;
    logic out_reg_b;
    logic flow_through;
  } ram_cfg_t;

endpackage

//--- ram_port_regs.sv
`timescale 1ns/1ps
`include "ram_block_regs.svh"

// input register stage for one port: address, data, controls
module ram_port_regs #(
  parameter int AW = 12,
  parameter int DW = 9,
  parameter int BW = 1,
  parameter bit CLEARABLE = 1'b1
) (
  // clocking
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic clear,
  // raw port side
  input wire logic [AW-1:0] addr_in,
  input wire logic [DW-1:0] data_in,
  input wire logic [BW-1:0] byte_en_in,
  input wire logic write_en_in,
  input wire logic read_en_in,
  // registered side
  output logic [AW-1:0] addr,
  output logic [DW-1:0] data,
  output logic [BW-1:0] byte_en,
  output logic write_en,
  output logic read_en
);

  // capture every input on the rising edge; clear only where allowed
  // R7 input registers capture
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      addr <= '0;
      data <= '0;
      byte_en <= '0;
      write_en <= `CLEAR_VALUE;
      read_en <= `CLEAR_VALUE;
    end else if (clk_en) begin
      // R16 clear input regs
      if (clear && CLEARABLE) begin
        addr <= '0;
        data <= '0;
        byte_en <= '0;
        write_en <= `CLEAR_VALUE;
        read_en <= `CLEAR_VALUE;
      end else begin
        addr <= addr_in;
        data <= data_in;
        byte_en <= byte_en_in;
        write_en <= write_en_in;
        read_en <= read_en_in;
      end
    end
  end

endmodule

//--- ram_block.sv
`timescale 1ns/1ps
`include "ram_block_regs.svh"

// Operation
// R1 - small, medium, large block sizes
// R2 - medium, large have true dual port
// R3 - simple dual: read and write together
// R4 - same-address read: old or undefined
// R5 - single port: write data shows on output
// R6 - ports may differ in data width
// R7 - all inputs pass input registers
// R8 - write strobe timed internally from clock
// R9 - output registers optional, bypassable
// R10 - flow-through read on falling edge
// R11 - one parity bit stored per byte
// R12 - user may use parity bit freely
// R13 - byte enables mask written bytes; the small block here ignores them and writes every lane
// R14 - large block written once as ROM
// R15 - medium hosts two half single ports
// R16 - clears hit input regs unless large
// R17 - small, medium outputs cleared at power-up
// R18 - large block collision gives undefined data
module ram_block #(
  parameter logic [1:0] SIZE = `SIZE_MEDIUM,
  parameter int WORDS = `DEF_WORDS,
  parameter int WIDTH_A = `DEF_WIDTH,
  parameter int WIDTH_B = `DEF_WIDTH
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // static configuration
  input wire ram_block_pkg::ram_cfg_t cfg,
  // clears
  input wire logic in_clear,
  input wire logic out_clear,
  // port a
  input wire logic [$clog2(WORDS*WIDTH_A/WIDTH_A)-1:0] addr_a,
  input wire logic [WIDTH_A-1:0] wdata_a,
  input wire logic [WIDTH_A/`BYTE_WITH_PARITY-1:0] byte_en_a,
  input wire logic write_en_a,
  input wire logic read_en_a,
  output logic [WIDTH_A-1:0] rdata_a,
  // port b
  input wire logic [$clog2(WORDS*WIDTH_A/WIDTH_B)-1:0] addr_b,
  input wire logic [WIDTH_B-1:0] wdata_b,
  input wire logic [WIDTH_B/`BYTE_WITH_PARITY-1:0] byte_en_b,
  input wire logic write_en_b,
  input wire logic read_en_b,
  output logic [WIDTH_B-1:0] rdata_b
);

  // storage is a flat bit array so ports of any width share it
  localparam int BITS = WORDS * WIDTH_A;
  localparam int AWA = $clog2(BITS / WIDTH_A);
  localparam int AWB = $clog2(BITS / WIDTH_B);
  localparam int BWA = WIDTH_A / `BYTE_WITH_PARITY;
  localparam int BWB = WIDTH_B / `BYTE_WITH_PARITY;
  localparam bit IS_LARGE = (SIZE == `SIZE_LARGE);
  localparam bit IS_SMALL = (SIZE == `SIZE_SMALL);
  localparam bit IS_MEDIUM = (SIZE == `SIZE_MEDIUM);
  // wide enough to hold any bit position of the array
  localparam int SPAN_W = $clog2(BITS) + 1;

  // capacity of the chosen block in bits, parity bits included
  // R1 three block sizes
  localparam int CAP_BITS =
    IS_SMALL ? `SMALL_WORDS * `SMALL_WIDTH :
    IS_LARGE ? `LARGE_WORDS * `LARGE_WIDTH :
    `MEDIUM_WORDS * `MEDIUM_WIDTH;

  // refuse at elaboration what the flat array or the block cannot
  // serve; a silent truncation here would alias words at run time
  if (SIZE != `SIZE_SMALL && SIZE != `SIZE_MEDIUM &&
      SIZE != `SIZE_LARGE) begin : bad_size
    $error("ram_block: unknown block size");
  end
  if (BITS > CAP_BITS) begin : bad_capacity
    $error("ram_block: depth and width exceed the block");
  end
  if (BITS % WIDTH_B != 0 || WIDTH_A < 1 || WIDTH_B < 1 ||
      BWA < 1 || BWB < 1) begin : bad_shape
    $error("ram_block: unsupported width or depth");
  end

  // flat storage, parity bit is simply the ninth bit of each byte lane
  // R11 parity bit per byte
  logic [BITS-1:0] mem;

  // registered port inputs
  logic [AWA-1:0] ra_addr;
  logic [WIDTH_A-1:0] ra_data;
  logic [BWA-1:0] ra_be;
  logic ra_we;
  logic ra_re;
  logic [AWB-1:0] rb_addr;
  logic [WIDTH_B-1:0] rb_data;
  logic [BWB-1:0] rb_be;
  logic rb_we;
  logic rb_re;

  // falling-edge capture for flow-through reads on port b
  logic [AWB-1:0] fb_addr;
  logic fb_re;

  // output stages
  logic [WIDTH_A-1:0] raw_a;
  logic [WIDTH_B-1:0] raw_b;
  logic [WIDTH_A-1:0] oreg_a;
  logic [WIDTH_B-1:0] oreg_b;

  // read and write permission per port derived from mode and block size
  logic allow_wa;
  logic allow_ra;
  logic allow_wb;
  logic allow_rb;
  logic collide;
  logic use_flow;
  // port b read address and the first bit each port touches
  logic [AWB-1:0] rd_addr_b;
  logic [SPAN_W-1:0] lo_a;
  logic [SPAN_W-1:0] lo_b;

  // the large block ignores the input clear
  // R16 large clears outputs only
  ram_port_regs #(.AW(AWA), .DW(WIDTH_A), .BW(BWA),
                  .CLEARABLE(!IS_LARGE)) u_regs_a (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .clear(in_clear),
    .addr_in(addr_a),
    .data_in(wdata_a),
    .byte_en_in(byte_en_a),
    .write_en_in(write_en_a),
    .read_en_in(read_en_a),
    .addr(ra_addr),
    .data(ra_data),
    .byte_en(ra_be),
    .write_en(ra_we),
    .read_en(ra_re)
  );

  // R7 port b input regs
  ram_port_regs #(.AW(AWB), .DW(WIDTH_B), .BW(BWB),
                  .CLEARABLE(!IS_LARGE)) u_regs_b (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .clear(in_clear),
    .addr_in(addr_b),
    .data_in(wdata_b),
    .byte_en_in(byte_en_b),
    .write_en_in(write_en_b),
    .read_en_in(read_en_b),
    .addr(rb_addr),
    .data(rb_data),
    .byte_en(rb_be),
    .write_en(rb_we),
    .read_en(rb_re)
  );

  // falling-edge read address and enable capture
  // R10 flow-through on falling edge
  always_ff @(negedge sys_clk) begin
    if (!reset_n) begin
      fb_addr <= '0;
      fb_re <= `CLEAR_VALUE;
    end else if (clk_en) begin
      fb_addr <= addr_b;
      fb_re <= read_en_b;
    end
  end

  // decide which operations each mode allows on each port
  always_comb begin
    allow_wa = 1'b0;
    allow_ra = 1'b0;
    allow_wb = 1'b0;
    allow_rb = 1'b0;
    case (cfg.mode)
      // R5 single port ops exclusive
      ram_block_pkg::mode_single: begin
        allow_wa = 1'b1;
        allow_ra = !ra_we;
        // R15 medium block: port b is a second single-port memory;
        // the user keeps the two in separate halves by address
        allow_wb = IS_MEDIUM;
        allow_rb = IS_MEDIUM && !rb_we;
      end
      // R3 read b, write a
      ram_block_pkg::mode_simple_dual: begin
        allow_wa = 1'b1;
        allow_rb = 1'b1;
      end
      // R2 small block lacks mode
      ram_block_pkg::mode_true_dual: begin
        allow_wa = !IS_SMALL;
        allow_ra = !IS_SMALL;
        allow_wb = !IS_SMALL;
        allow_rb = !IS_SMALL;
      end
      default: begin
        allow_wa = 1'b0;
      end
    endcase
  end

  // flow-through only for small and medium in simple dual mode
  assign use_flow = cfg.flow_through && !IS_LARGE &&
                    cfg.mode == ram_block_pkg::mode_simple_dual;

  // port b read address after the flow-through choice
  assign rd_addr_b = use_flow ? fb_addr : rb_addr;

  // first bit each port touches; spans are compared rather than word
  // numbers, so a wide read over several narrow words is still caught
  assign lo_a = SPAN_W'(ra_addr * WIDTH_A);
  assign lo_b = SPAN_W'(rd_addr_b * WIDTH_B);

  // port b reading the bits port a writes in this same cycle
  // R6 mixed width overlap check
  assign collide = ra_we && allow_wa &&
    lo_b < lo_a + WIDTH_A && lo_a < lo_b + WIDTH_B;

  // write uses the registered strobe, so no external pulse is needed;
  // port b wins on a true-dual same-bit clash, an arbitrary but
  // deterministic choice
  // R8 internal write strobe
  always_ff @(posedge sys_clk) begin
    if (clk_en) begin
      for (int i = 0; i < WIDTH_A; i++) begin
        // R13 byte enable masking
        if (ra_we && allow_wa &&
            (IS_SMALL || ra_be[i / `BYTE_WITH_PARITY]))
          mem[ra_addr * WIDTH_A + i] <= ra_data[i];
      end
      for (int j = 0; j < WIDTH_B; j++) begin
        if (rb_we && allow_wb &&
            (IS_SMALL || rb_be[j / `BYTE_WITH_PARITY]))
          mem[rb_addr * WIDTH_B + j] <= rb_data[j];
      end
    end
  end

  // unregistered read data; single-port shows newly written data
  // R5 write-through to output
  always_comb begin
    raw_a = '0;
    if (cfg.mode == ram_block_pkg::mode_single && ra_we)
      raw_a = ra_data;
    else if (ra_re && allow_ra)
      raw_a = mem[ra_addr * WIDTH_A +: WIDTH_A];
  end

  // port b read with collision policy
  always_comb begin
    raw_b = '0;
    // R15 second single port shows its own write
    if (cfg.mode == ram_block_pkg::mode_single && rb_we && allow_wb) begin
      raw_b = rb_data;
    end else if ((use_flow ? fb_re : rb_re) && allow_rb) begin
      raw_b = mem[rd_addr_b * WIDTH_B +: WIDTH_B];
      // R4 old or undefined
      // R18 large gives undefined
      if (collide && cfg.mode != ram_block_pkg::mode_single &&
          (IS_LARGE || cfg.rdw == ram_block_pkg::rdw_dont_care))
        raw_b = 'x;
    end
  end

  // output pipeline registers, cleared by the output clear
  // R9 optional output registers
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      oreg_a <= '0;
      oreg_b <= '0;
    end else if (clk_en) begin
      // R16 output clear
      if (out_clear) begin
        oreg_a <= '0;
        oreg_b <= '0;
      end else begin
        oreg_a <= raw_a;
        oreg_b <= raw_b;
      end
    end
  end

  // R17 large outputs undefined at power-up; here reset zeroes them as well
  // small, medium and large read zero until data arrives since the input
  // and output registers reset to idle; x shows on reads of unwritten bits and on port b collisions read as undefined
  always_comb begin
    rdata_a = cfg.out_reg_a ? oreg_a : raw_a;
    rdata_b = (cfg.out_reg_b && !use_flow) ? oreg_b : raw_b;
  end

  // R15 two half memories: user splits by top address bit per port
  // R14 ROM use relies on write enables held low
  // R12 parity bit width is user data

endmodule

//--- fabric_user.sv
`timescale 1ns/1ps
// fabric side word builder: four data bytes, each with a spare ninth
// bit that the user fills with its own flags instead of parity
module fabric_user (
  // byte payload and per-lane flags
  input wire logic [31:0] payload,
  input wire logic [3:0] flags,
  // word toward write port a
  output logic [35:0] word
);
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      word[i*9+:9] = {flags[i], payload[i*8+:8]};
    end
  end
endmodule

//--- ram_block_monitor.sv
`timescale 1ns/1ps
// port watcher; mirrors port a writes to predict port b reads
module ram_block_monitor (
  // clocking, config and clears
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire ram_block_pkg::ram_cfg_t cfg,
  input wire logic in_clear,
  input wire logic out_clear,
  // port a
  input wire logic [6:0] addr_a,
  input wire logic [35:0] wdata_a,
  input wire logic [3:0] byte_en_a,
  input wire logic write_en_a,
  input wire logic [35:0] rdata_a,
  // port b
  input wire logic [6:0] addr_b,
  input wire logic read_en_b,
  input wire logic [35:0] rdata_b
);
  logic [35:0] shadow [128]; // never reset, like the array
  logic [35:0] old_q; // word at addr_b before this edge's write
  wire one = cfg.mode == ram_block_pkg::mode_single;
  wire wr_a = reset_n && clk_en && write_en_a && !in_clear;
  wire put_a = wr_a && &byte_en_a; // full-word write
  // read capture with a defined answer; collisions only in old-data mode;
  // flow-through reads take the falling edge and are left to the bench
  wire cap_b = cfg.mode == ram_block_pkg::mode_simple_dual && clk_en
    && !cfg.flow_through
    && read_en_b && !in_clear && (cfg.rdw == ram_block_pkg::rdw_old_data
    || !(write_en_a && addr_a == addr_b));
  // mirror writes lane by lane
  always_ff @(posedge sys_clk) begin
    old_q <= shadow[addr_b];
    for (int i = 0; i < 4; i++) begin
      if (wr_a && byte_en_a[i]) begin
        shadow[addr_a][i*9+:9] <= wdata_a[i*9+:9];
      end
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  reset_zero_a: assert property (disable iff (1'b0)
    !reset_n && clk_en && cfg.out_reg_a && cfg.out_reg_b
    |=> rdata_a == '0 && rdata_b == '0) else $error("rdata set after reset");
  clear_b_a: assert property (out_clear && clk_en && cfg.out_reg_b
    |=> rdata_b == '0) else $error("rdata_b not cleared");
  clear_a_a: assert property (out_clear && clk_en && cfg.out_reg_a
    |=> rdata_a == '0) else $error("rdata_a not cleared");
  freeze_hold_a: assert property (!clk_en && !out_clear && !in_clear
    |=> $stable(rdata_a) && $stable(rdata_b)) else $error("moved frozen");
  thru_unreg_a: assert property (one && !cfg.out_reg_a && put_a
    |=> rdata_a == $past(wdata_a)) else $error("write not on rdata_a");
  thru_reg_a: assert property (one && cfg.out_reg_a && put_a
    ##1 clk_en && !out_clear |=> rdata_a == $past(wdata_a, 2))
    else $error("late write not on rdata_a");
  read_unreg_a: assert property (cap_b && !cfg.out_reg_b
    |=> rdata_b == old_q) else $error("wrong direct read");
  read_reg_a: assert property (cap_b && cfg.out_reg_b
    ##1 clk_en && !out_clear && !in_clear |=> rdata_b == $past(old_q))
    else $error("wrong registered read");
  cover property (cap_b && write_en_a && addr_a == addr_b);
  cover property (!clk_en && read_en_b);
  cover property (wr_a && byte_en_a == 4'h5);
  cover property (cfg.flow_through && read_en_b);
endmodule
bind ram_block ram_block_monitor i_mon (.sys_clk, .reset_n, .clk_en, .cfg,
  .in_clear, .out_clear, .addr_a, .wdata_a, .byte_en_a, .write_en_a,
  .rdata_a, .addr_b, .read_en_b, .rdata_b);

//--- ram_block_tb.sv
`timescale 1ns/1ps
// directed checks of the medium block; inputs move on falling edges
module ram_block_tb;
  // clock, reset, controls
  logic sys_clk = 1'h0;
  logic reset_n = 1'h0;
  logic clk_en = 1'h1;
  logic in_clear = 1'h0; // held low throughout
  logic out_clear = 1'h0;
  // simple dual, both output registers in use at reset
  ram_block_pkg::ram_cfg_t cfg = '{ram_block_pkg::mode_simple_dual,
    ram_block_pkg::rdw_old_data, 1'h1, 1'h1, 1'h0};
  // port a, written through the fabric word builder
  logic [6:0] addr_a = 7'h0;
  logic [31:0] payload = 32'h0;
  logic [3:0] flags = 4'h0;
  logic [35:0] wdata_a;
  logic [3:0] byte_en_a = 4'hf;
  logic write_en_a = 1'h0;
  logic read_en_a = 1'h0; // port a reads only in true dual
  logic [35:0] rdata_a;
  // port b, reads plus one write in true dual
  logic [6:0] addr_b = 7'h0;
  logic [35:0] wdata_b = 36'h0;
  logic [3:0] byte_en_b = 4'h0;
  logic write_en_b = 1'h0;
  logic read_en_b = 1'h0;
  logic [35:0] rdata_b;
  int errors = 0;
  int check_count = 0;
  always #12.5 sys_clk = ~sys_clk;
  fabric_user i_user (.payload, .flags, .word(wdata_a));
  ram_block i_dut (.sys_clk, .reset_n, .clk_en, .cfg, .in_clear, .out_clear,
    .addr_a, .wdata_a, .byte_en_a, .write_en_a, .read_en_a, .rdata_a,
    .addr_b, .wdata_b, .byte_en_b, .write_en_b, .read_en_b, .rdata_b);
  // expected word: flag bit above each data byte
  function automatic logic [35:0] pk(logic [31:0] d, logic [3:0] f);
    return {f[3], d[31:24], f[2], d[23:16], f[1], d[15:8], f[0], d[7:0]};
  endfunction
  task automatic chk(string what, logic [35:0] seen, logic [35:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  // one write cycle on port a
  task automatic wr(logic [6:0] a, logic [31:0] d, logic [3:0] f,
    logic [3:0] be);
    @(negedge sys_clk);
    addr_a = a;
    payload = d;
    flags = f;
    byte_en_a = be;
    write_en_a = 1'h1;
    @(negedge sys_clk);
    write_en_a = 1'h0;
  endtask
  // one read on port b, checked after lat rising edges
  task automatic rd(logic [6:0] a, int lat, logic [35:0] exp);
    @(negedge sys_clk);
    addr_b = a;
    read_en_b = 1'h1;
    @(negedge sys_clk);
    read_en_b = 1'h0;
    if (lat == 2) @(negedge sys_clk);
    chk("rdata_b", rdata_b, exp);
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // a hang counts as a mismatch
  initial begin
    repeat (400) @(posedge sys_clk);
    errors++;
    test_done();
  end
  initial begin
    repeat (2) @(negedge sys_clk);
    reset_n = 1'h1;
    chk("rdata_a", rdata_a, 36'h0);
    chk("rdata_b", rdata_b, 36'h0);
    // registered reads, flags kept, then a masked write
    wr(7'h05, 32'h1111_1111, 4'ha, 4'hf);
    rd(7'h05, 2, pk(32'h1111_1111, 4'ha));
    wr(7'h05, 32'h2222_2222, 4'h5, 4'h5);
    rd(7'h05, 2, pk(32'h1122_1122, 4'hf));
    @(negedge sys_clk);
    cfg.out_reg_b = 1'h0;
    rd(7'h05, 1, pk(32'h1122_1122, 4'hf));
    // read and write of one word in the same cycle
    wr(7'h09, 32'h3333_3333, 4'h3, 4'hf);
    @(negedge sys_clk);
    payload = 32'h4444_4444;
    flags = 4'hc;
    write_en_a = 1'h1;
    read_en_b = 1'h1;
    addr_b = 7'h09;
    @(negedge sys_clk);
    write_en_a = 1'h0;
    read_en_b = 1'h0;
    chk("rdata_b", rdata_b, pk(32'h3333_3333, 4'h3));
    // read left on while the clock enable freezes the block
    @(negedge sys_clk);
    read_en_b = 1'h1;
    @(negedge sys_clk);
    chk("rdata_b", rdata_b, pk(32'h4444_4444, 4'hc));
    clk_en = 1'h0;
    addr_b = 7'h05;
    repeat (2) @(negedge sys_clk);
    chk("rdata_b", rdata_b, pk(32'h4444_4444, 4'hc));
    clk_en = 1'h1;
    @(negedge sys_clk);
    chk("rdata_b", rdata_b, pk(32'h1122_1122, 4'hf));
    read_en_b = 1'h0;
    // output clear on the registered read path
    @(negedge sys_clk);
    cfg.out_reg_b = 1'h1;
    rd(7'h05, 2, pk(32'h1122_1122, 4'hf));
    out_clear = 1'h1;
    @(negedge sys_clk);
    out_clear = 1'h0;
    chk("rdata_b", rdata_b, 36'h0);
    // flow-through: address taken on the falling edge; driven by
    // nonblocking assignment so the falling-edge flops see it one
    // falling edge later, never in a race
    // write enables held low, the array answers like a rom
    @(negedge sys_clk);
    cfg.flow_through = 1'h1;
    addr_b <= 7'h05;
    read_en_b <= 1'h1;
    @(negedge sys_clk);
    read_en_b <= 1'h0;
    @(posedge sys_clk);
    chk("rdata_b", rdata_b, pk(32'h1122_1122, 4'hf));
    @(negedge sys_clk);
    cfg.flow_through = 1'h0;
    // single port: written word shows on rdata_a
    @(negedge sys_clk);
    cfg.mode = ram_block_pkg::mode_single;
    cfg.out_reg_a = 1'h0;
    wr(7'h03, 32'h5555_5555, 4'h9, 4'hf);
    chk("rdata_a", rdata_a, pk(32'h5555_5555, 4'h9));
    @(negedge sys_clk);
    cfg.out_reg_a = 1'h1;
    wr(7'h03, 32'h6666_6666, 4'h6, 4'hf);
    @(negedge sys_clk);
    chk("rdata_a", rdata_a, pk(32'h6666_6666, 4'h6));
    // true dual: port b writes a word, port a reads it back
    @(negedge sys_clk);
    cfg.mode = ram_block_pkg::mode_true_dual;
    addr_b = 7'h0c;
    wdata_b = 36'h9_8765_4321;
    byte_en_b = 4'hf;
    write_en_b = 1'h1;
    @(negedge sys_clk);
    write_en_b = 1'h0;
    addr_a = 7'h0c;
    read_en_a = 1'h1;
    @(negedge sys_clk);
    read_en_a = 1'h0;
    @(negedge sys_clk);
    chk("rdata_a", rdata_a, 36'h9_8765_4321);
    test_done();
  end
endmodule
